// file: design/sfwp_regs.svh
/*
  Constants of the write-protect block: opcodes, bit positions, geometry.
  Assumes a 4 MB array of 64 KB blocks and 4 KB sectors, SPI mode 0 or 3.
*/
// Notes on behaviour
// (R1) Power-up leaves write enable latch cleared.
// (R2) Write enable required before program, erase, status write.
// (R3) Finished program, erase, status write clear latch.
// (R4) Latch set by enable, cleared by listed instructions.
// (R5) Power-up lockout refuses enable, program, erase, writes.
// (R6) Power-down ignores all but release instruction.
// (R7) Lock bit per block; per sector at ends.
// (R8) Locked region ignores program and erase.
// (R9) All lock bits set at power-on; unlock clears.
// (R10) Scheme select picks range bits or lock bits.
// (R11) Busy flag during operations; only status, suspend accepted.
// (R12) Status writes gated by mode bits, latch, pin.
// (R13) Range bits choose protected amount; default none.
// (R14) Top/bottom select: top at 0, bottom at 1.
// (R15) Sector/block select: sectors at 1, blocks at 0.
// (R16) Complement bit inverts protected region.
// (R17) Protect mode bits sit at S8 and S7.
// (R18) Mode 00: writable whenever latch set.
// (R19) Mode 01: locked while pin low.
// (R20) Mode 10: locked until next power cycle.
// (R21) Mode 11: status register locked permanently; the code clears this mode at power-on reset.
// (R22) Power cycle returns mode 10 to 00.
// (R23) Protected target: array untouched, busy stays clear.
`ifndef SFWP_REGS_SVH
`define SFWP_REGS_SVH

`define SFWP_OP_WREN   8'h06
`define SFWP_OP_WRDI   8'h04
`define SFWP_OP_RDSR1  8'h05
`define SFWP_OP_RDSR2  8'h35
`define SFWP_OP_RDSR3  8'h15
`define SFWP_OP_WRSR1  8'h01
`define SFWP_OP_WRSR2  8'h31
`define SFWP_OP_WRSR3  8'h11
`define SFWP_OP_PP     8'h02
`define SFWP_OP_QPP    8'h32
`define SFWP_OP_SE     8'h20
`define SFWP_OP_BE32   8'h52
`define SFWP_OP_BE64   8'hD8
`define SFWP_OP_CE1    8'hC7
`define SFWP_OP_CE2    8'h60
`define SFWP_OP_SECER  8'h44
`define SFWP_OP_SECPG  8'h42
`define SFWP_OP_PD     8'hB9
`define SFWP_OP_RPD    8'hAB
`define SFWP_OP_UNLOCK 8'h39
`define SFWP_OP_SUSP   8'h75

// Status bit positions within each byte.
`define SFWP_SR1_BUSY  0
`define SFWP_SR1_WEL   1
`define SFWP_SR1_BP_LO 2
`define SFWP_SR1_BP_HI 4
`define SFWP_SR1_TB    5
`define SFWP_SR1_SEC   6
`define SFWP_SR1_SRPL  7
`define SFWP_SR2_SRPU  0
`define SFWP_SR2_QE    1
`define SFWP_SR2_CMP   6
`define SFWP_SR3_WPS   2

// Reset values of the protection fields.
`define SFWP_BP_RST    3'h0
`define SFWP_SRP_RST   1'b0
`define SFWP_LOCK_RST  1'b1

// Frame layout: the first 48 bits of each frame, opcode first.
`define SFWP_FRAME_BITS 6'd48
`define SFWP_OP_MSB     47
`define SFWP_OP_LSB     40
`define SFWP_B1_MSB     39
`define SFWP_B1_LSB     32
`define SFWP_B2_LSB     24
`define SFWP_SECT_MSB   37
`define SFWP_SECT_LSB   28
`define SFWP_LEN_OP     6'd8
`define SFWP_LEN_B1     6'd16
`define SFWP_LEN_B2     6'd24
`define SFWP_LEN_ADDR   6'd32
`define SFWP_LEN_DATA   6'd40

// Array geometry in 4 KB sectors.
`define SFWP_SECTORS    11'd1024
`define SFWP_SPB        11'd16
`define SFWP_SEC_MAXN   11'd8
`define SFWP_BP_ALL     3'h7
`define SFWP_LOCK_BITS  94
`define SFWP_BOT_LOCKS  16
`define SFWP_MID_BASE   32
`define SFWP_TOP_SECT0  1008
`define SFWP_SECT_SPAN  15

// Timing: core clock rate and default durations in microseconds.
`define SFWP_CLK_MHZ    50
`define SFWP_PUW_US     1000
`define SFWP_SRW_US     15

`endif

// file: design/sfwp_pkg.sv
/*
  Types shared by the write-protect block: busy sequencer states and the
  kind code handed to the array engine. Assumes nothing of its users.
*/
package sfwp_pkg;

  // Gray codes along idle -> operation -> idle.
  typedef enum logic [1:0] {
    SFWP_IDLE  = 2'b00,
    SFWP_ARRAY = 2'b01,
    SFWP_SRW   = 2'b10
  } sfwp_busy_e;

  typedef enum logic [2:0] {
    SFWP_K_PP    = 3'h0,
    SFWP_K_QPP   = 3'h1,
    SFWP_K_SE    = 3'h2,
    SFWP_K_BE32  = 3'h3,
    SFWP_K_BE64  = 3'h4,
    SFWP_K_CE    = 3'h5,
    SFWP_K_SECER = 3'h6,
    SFWP_K_SECPG = 3'h7
  } sfwp_kind_e;

endpackage : sfwp_pkg

// file: design/sfwp_write_protect.sv
/*
  Write-protect and status logic of a serial flash. The link side captures
  each frame; the core side decides at frame end what it may change.
  Assumes an array engine on core_clk_i that answers array_go_o with one
  array_done_i pulse, and that the host holds CS high while SCLK is idle.
*/
`timescale 1ns/1ns
`include "sfwp_regs.svh"

module sfwp_write_protect
  import sfwp_pkg::*;
#(
  parameter int unsigned PUW_CYCLES = `SFWP_PUW_US * `SFWP_CLK_MHZ
) (
  input  wire logic        core_clk_i,    // Core clock, 50 MHz.
  input  wire logic        rstn_i,        // Power-on reset, active low.
  input  wire logic        sclk_i,        // Serial link clock.
  input  wire logic        cs_n_i,        // Chip select, active low.
  input  wire logic        mosi_i,        // Serial data in.
  input  wire logic        wp_n_i,        // Write protect pin, active low.
  input  wire logic        array_done_i,  // Array engine finished.
  output logic             miso_o,        // Serial data out.
  output logic             miso_oe_o,     // Serial data out enable.
  output logic             array_go_o,    // Start pulse to array engine.
  output logic [2:0]       array_kind_o,  // Operation kind.
  output logic [23:0]      array_addr_o,  // Operation address.
  output logic             suspend_o,     // Suspend pulse to array engine.
  output logic             busy_o,        // Operation in progress.
  output logic             power_down_o   // Deep power-down active.
);

  localparam int unsigned SRW_CYCLES = `SFWP_SRW_US * `SFWP_CLK_MHZ;

  // Link domain state.
  logic        link_rst;
  logic [5:0]  bit_cnt_r;
  logic [47:0] frame_r;
  logic [5:0]  frame_len_r;
  logic        frame_tog_r;
  logic        miso_r;
  logic        miso_oe_r;
  logic [7:0]  rd_byte;
  logic [7:0]  link_op;

  // Core domain state.
  logic        cs_s1_r, cs_s2_r, cs_s3_r;
  logic        tog_s1_r, tog_s2_r, seen_r;
  logic        wp_s1_r, wp_s2_r;
  logic        frame_new;
  sfwp_busy_e  bst_r;
  logic [15:0] srw_cnt_r;
  logic [31:0] puw_cnt_r;
  logic        wel_r, pd_r;
  logic [2:0]  bp_r;
  logic        tb_r, sec_r, cmp_r, srpl_r, srpu_r, qe_r, wps_r;
  logic [`SFWP_LOCK_BITS-1:0] lock_r;
  logic [7:0]  sr1, sr2, sr3;
  logic [7:0]  snap1_r, snap2_r, snap3_r;
  logic        snap_pd_r;

  // Decisions taken at the end of a frame.
  logic [7:0]  op;
  logic [5:0]  len;
  logic [9:0]  sect, first, last;
  logic        lockout, busy, prot, sr_ok, wr_ok, arr_ok;
  logic        do_wren, do_clr, do_srw, do_go, do_unlock, do_pd, do_rpd, do_susp;
  sfwp_kind_e  kind;

  // Range protection of one sector.
  function automatic logic range_hit(input logic [9:0] s, input logic [2:0] bp,
                                     input logic tb, input logic sc, input logic cm);
    logic [10:0] n;
    logic        inr;
    n = '0;
    if (bp == `SFWP_BP_ALL) begin
      n = `SFWP_SECTORS;
    end else if (bp != `SFWP_BP_RST) begin
      if (!sc) begin
        n = `SFWP_SPB << (bp - 3'd1);                     // R15
      end else if (bp[2]) begin
        n = `SFWP_SEC_MAXN;
      end else begin
        n = 11'd1 << (bp - 3'd1);
      end
    end
    inr = tb ? ({1'b0, s} < n) : ({1'b0, s} >= (`SFWP_SECTORS - n)); // R14
    return inr ^ cm;                                      // R16
  endfunction

  // Lock bit index of a sector: sectors in the end blocks, blocks elsewhere.
  function automatic logic [6:0] lock_idx(input logic [9:0] s);
    logic [6:0] idx;
    if (s[9:4] == '0) begin
      idx = {3'b000, s[3:0]};
    end else if (s[9:4] == '1) begin
      idx = 7'(`SFWP_BOT_LOCKS) + {3'b000, s[3:0]};
    end else begin
      idx = 7'(`SFWP_MID_BASE) + {1'b0, s[9:4]} - 7'd1;
    end
    return idx;                                           // R7
  endfunction

  // Any set lock bit whose region overlaps the sector span.
  function automatic logic lock_hit(input logic [9:0] f, input logic [9:0] l,
                                    input logic [`SFWP_LOCK_BITS-1:0] lk);
    logic       hit;
    logic [9:0] lo, hi;
    hit = 1'b0;
    lo  = '0;
    hi  = '0;
    for (int j = 0; j < `SFWP_LOCK_BITS; j++) begin
      if (j < `SFWP_BOT_LOCKS) begin
        lo = 10'(j);
        hi = lo;
      end else if (j < `SFWP_MID_BASE) begin
        lo = 10'(`SFWP_TOP_SECT0 + j - `SFWP_BOT_LOCKS);
        hi = lo;
      end else begin
        lo = 10'((j - `SFWP_MID_BASE + 1) * 16);
        hi = lo + 10'(`SFWP_SECT_SPAN);
      end
      if (lk[j] && lo <= l && hi >= f) begin
        hit = 1'b1;                                       // R8
      end
    end
    return hit;
  endfunction

  // Frame reset: a frame ends by its own chip select, so the link logic
  // never waits on a clock edge after the last one.
  assign link_rst = cs_n_i | ~rstn_i;

  // Bit counter, cleared between frames; saturates at the 48-bit frame width.
  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r < `SFWP_FRAME_BITS) begin
      bit_cnt_r <= bit_cnt_r + 6'd1;
    end
  end

  // Frame capture. These registers hold still after the frame, which is
  // what lets the core read them once chip select has crossed.
  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_r     <= '0;
      frame_len_r <= '0;
      frame_tog_r <= 1'b0;
    end else begin
      if (bit_cnt_r < `SFWP_FRAME_BITS) begin
        frame_r[6'(`SFWP_OP_MSB) - bit_cnt_r] <= mosi_i;
        frame_len_r <= bit_cnt_r + 6'd1;
      end
      if (bit_cnt_r == '0) begin
        frame_tog_r <= ~frame_tog_r;
      end
    end
  end

  // Status byte chosen by the opcode; the snapshot is frozen during frames.
  assign link_op = frame_r[`SFWP_OP_MSB:`SFWP_OP_LSB];
  always_comb begin
    case (link_op)
      `SFWP_OP_RDSR1: rd_byte = snap1_r;
      `SFWP_OP_RDSR2: rd_byte = snap2_r;
      `SFWP_OP_RDSR3: rd_byte = snap3_r;
      default:        rd_byte = '0;
    endcase
  end

  // Read data leaves on the falling edge; nothing is driven in power-down.
  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
    end else if (bit_cnt_r >= `SFWP_LEN_OP && !snap_pd_r &&
                 (link_op == `SFWP_OP_RDSR1 || link_op == `SFWP_OP_RDSR2 ||
                  link_op == `SFWP_OP_RDSR3)) begin    // R6
      miso_oe_r <= 1'b1;
      miso_r    <= rd_byte[~bit_cnt_r[2:0]];
    end
  end

  assign miso_o    = miso_r;
  assign miso_oe_o = miso_oe_r;

  // Synchronisers for chip select, the frame toggle and the protect pin.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      cs_s3_r  <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      seen_r   <= 1'b0;
      wp_s1_r  <= 1'b0;
      wp_s2_r  <= 1'b0;
    end else begin
      cs_s1_r  <= cs_n_i;
      cs_s2_r  <= cs_s1_r;
      cs_s3_r  <= cs_s2_r;
      tog_s1_r <= frame_tog_r;
      tog_s2_r <= tog_s1_r;
      wp_s1_r  <= wp_n_i;
      wp_s2_r  <= wp_s1_r;
      if (cs_s2_r && !cs_s3_r) begin
        seen_r <= tog_s2_r;
      end
    end
  end

  // A frame counts only if it carried at least one clock edge.
  assign frame_new = cs_s2_r && !cs_s3_r && (tog_s2_r != seen_r);

  assign op      = frame_r[`SFWP_OP_MSB:`SFWP_OP_LSB];
  assign len     = frame_len_r;
  assign sect    = frame_r[`SFWP_SECT_MSB:`SFWP_SECT_LSB];
  assign lockout = puw_cnt_r != '0;
  assign busy    = bst_r != SFWP_IDLE;
  assign wr_ok   = wel_r && !lockout;

  // Status write permission from the mode bits, the latch and the pin; the
  // pin only counts while its quad function is off.
  always_comb begin
    unique case ({srpu_r, srpl_r})
      2'b00: sr_ok = wel_r;                               // R18
      2'b01: sr_ok = wel_r && (wp_s2_r || qe_r);          // R19
      2'b10: sr_ok = 1'b0;                                // R20
      2'b11: sr_ok = 1'b0;                                // R21
    endcase
  end

  // Sector span touched by the addressed command.
  always_comb begin
    first = sect;
    last  = sect;
    kind  = SFWP_K_PP;
    case (op)
      `SFWP_OP_QPP:   kind = SFWP_K_QPP;
      `SFWP_OP_SE:    kind = SFWP_K_SE;
      `SFWP_OP_BE32: begin
        kind  = SFWP_K_BE32;
        first = {sect[9:3], 3'b000};
        last  = {sect[9:3], 3'b111};
      end
      `SFWP_OP_BE64: begin
        kind  = SFWP_K_BE64;
        first = {sect[9:4], 4'h0};
        last  = {sect[9:4], 4'hF};
      end
      `SFWP_OP_CE1, `SFWP_OP_CE2: begin
        kind  = SFWP_K_CE;
        first = '0;
        last  = '1;
      end
      `SFWP_OP_SECER: kind = SFWP_K_SECER;
      `SFWP_OP_SECPG: kind = SFWP_K_SECPG;
      default:        kind = SFWP_K_PP;
    endcase
  end

  // Active protection scheme over the span.
  assign prot = wps_r ? lock_hit(first, last, lock_r)    // R10
                      : (range_hit(first, bp_r, tb_r, sec_r, cmp_r) ||
                         range_hit(last, bp_r, tb_r, sec_r, cmp_r)); // R13

  // Instruction acceptance at the end of each frame.
  always_comb begin
    do_wren   = 1'b0;
    do_clr    = 1'b0;
    do_srw    = 1'b0;
    do_go     = 1'b0;
    do_unlock = 1'b0;
    do_pd     = 1'b0;
    do_rpd    = 1'b0;
    do_susp   = 1'b0;
    arr_ok    = 1'b0;
    if (frame_new) begin
      if (pd_r) begin
        do_rpd = op == `SFWP_OP_RPD;                      // R6
      end else if (busy) begin
        do_susp = op == `SFWP_OP_SUSP && bst_r == SFWP_ARRAY; // R11
      end else begin
        case (op)
          `SFWP_OP_WREN:  do_wren = !lockout;             // R5
          `SFWP_OP_WRDI:  do_clr  = 1'b1;                 // R4
          `SFWP_OP_WRSR1, `SFWP_OP_WRSR2, `SFWP_OP_WRSR3:
            do_srw = sr_ok && !lockout && len >= `SFWP_LEN_B1; // R12
          `SFWP_OP_PP, `SFWP_OP_QPP:  arr_ok = len >= `SFWP_LEN_DATA;
          `SFWP_OP_SE, `SFWP_OP_BE32, `SFWP_OP_BE64:
            arr_ok = len >= `SFWP_LEN_ADDR;               // R8
          `SFWP_OP_CE1, `SFWP_OP_CE2: arr_ok = 1'b1;
          `SFWP_OP_SECER, `SFWP_OP_SECPG:
            do_go = wr_ok && len >= `SFWP_LEN_ADDR;
          `SFWP_OP_UNLOCK:
            do_unlock = wr_ok && len >= `SFWP_LEN_ADDR;
          `SFWP_OP_PD:    do_pd = 1'b1;
          default:        do_clr = 1'b0;
        endcase
        // A refused protected command still drops the latch.
        do_go  = do_go || (arr_ok && wr_ok && !prot);     // R2
        do_clr = do_clr || (arr_ok && wr_ok && prot);     // R23
      end
    end
  end

  // Power-up lockout counter.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      puw_cnt_r <= PUW_CYCLES;
    end else if (puw_cnt_r != '0) begin
      puw_cnt_r <= puw_cnt_r - 32'd1;                     // R5
    end
  end

  // Busy sequencer: array operations wait for the engine, status writes
  // take a fixed write time.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bst_r     <= SFWP_IDLE;
      srw_cnt_r <= '0;
    end else begin
      unique case (bst_r)
        SFWP_IDLE: begin
          if (do_go) begin
            bst_r <= SFWP_ARRAY;                          // R11
          end else if (do_srw) begin
            bst_r     <= SFWP_SRW;
            srw_cnt_r <= 16'(SRW_CYCLES);
          end
        end
        SFWP_ARRAY: if (array_done_i) bst_r <= SFWP_IDLE; // R11
        SFWP_SRW: begin
          srw_cnt_r <= srw_cnt_r - 16'd1;
          if (srw_cnt_r == 16'd1) begin
            bst_r <= SFWP_IDLE;
          end
        end
        default: bst_r <= SFWP_IDLE;
      endcase
    end
  end

  // Write enable latch: set by enable, cleared by disable, by unlock, by a refused
  // protected command and when any operation completes.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wel_r <= 1'b0;                                      // R1
    end else if (do_wren) begin
      wel_r <= 1'b1;                                      // R4
    end else if (do_clr || do_unlock ||
                 (bst_r == SFWP_ARRAY && array_done_i) ||
                 (bst_r == SFWP_SRW && srw_cnt_r == 16'd1)) begin
      wel_r <= 1'b0;                                      // R3
    end
  end

  // Protection fields; a power-on reset brings back the factory values,
  // which also releases the lock-down mode.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bp_r   <= `SFWP_BP_RST;                             // R13
      tb_r   <= 1'b0;
      sec_r  <= 1'b0;
      cmp_r  <= 1'b0;
      srpl_r <= `SFWP_SRP_RST;                            // R22
      srpu_r <= `SFWP_SRP_RST;
      qe_r   <= 1'b0;
      wps_r  <= 1'b0;
    end else if (do_srw) begin
      if (op == `SFWP_OP_WRSR1) begin
        bp_r   <= frame_r[`SFWP_B1_LSB + `SFWP_SR1_BP_HI:`SFWP_B1_LSB + `SFWP_SR1_BP_LO];
        tb_r   <= frame_r[`SFWP_B1_LSB + `SFWP_SR1_TB];
        sec_r  <= frame_r[`SFWP_B1_LSB + `SFWP_SR1_SEC];
        srpl_r <= frame_r[`SFWP_B1_LSB + `SFWP_SR1_SRPL];  // R17
        if (len >= `SFWP_LEN_B2) begin
          srpu_r <= frame_r[`SFWP_B2_LSB + `SFWP_SR2_SRPU];
          qe_r   <= frame_r[`SFWP_B2_LSB + `SFWP_SR2_QE];
          cmp_r  <= frame_r[`SFWP_B2_LSB + `SFWP_SR2_CMP];
        end
      end else if (op == `SFWP_OP_WRSR2) begin
        srpu_r <= frame_r[`SFWP_B1_LSB + `SFWP_SR2_SRPU];  // R17
        qe_r   <= frame_r[`SFWP_B1_LSB + `SFWP_SR2_QE];
        cmp_r  <= frame_r[`SFWP_B1_LSB + `SFWP_SR2_CMP];
      end else begin
        wps_r  <= frame_r[`SFWP_B1_LSB + `SFWP_SR3_WPS];
      end
    end
  end

  // Lock bits, all set at power-on and cleared one at a time.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_r <= {`SFWP_LOCK_BITS{`SFWP_LOCK_RST}};        // R9
    end else if (do_unlock) begin
      lock_r[lock_idx(sect)] <= 1'b0;                     // R9
    end
  end

  // Power-down state.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_r <= 1'b0;
    end else if (do_pd) begin
      pd_r <= 1'b1;
    end else if (do_rpd) begin
      pd_r <= 1'b0;
    end
  end

  // Engine handshake outputs.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      array_go_o   <= 1'b0;
      array_kind_o <= '0;
      array_addr_o <= '0;
      suspend_o    <= 1'b0;
    end else begin
      array_go_o <= do_go;
      suspend_o  <= do_susp;
      if (do_go) begin
        array_kind_o <= kind;
        array_addr_o <= frame_r[`SFWP_B1_MSB:`SFWP_B2_LSB - 8];
      end
    end
  end

  // Status bytes; reserved bits read as zero.
  always_comb begin
    sr1 = '0;
    sr2 = '0;
    sr3 = '0;
    sr1[`SFWP_SR1_BUSY] = busy;                           // R11
    sr1[`SFWP_SR1_WEL]  = wel_r;
    sr1[`SFWP_SR1_BP_HI:`SFWP_SR1_BP_LO] = bp_r;
    sr1[`SFWP_SR1_TB]   = tb_r;
    sr1[`SFWP_SR1_SEC]  = sec_r;
    sr1[`SFWP_SR1_SRPL] = srpl_r;
    sr2[`SFWP_SR2_SRPU] = srpu_r;
    sr2[`SFWP_SR2_QE]   = qe_r;
    sr2[`SFWP_SR2_CMP]  = cmp_r;
    sr3[`SFWP_SR3_WPS]  = wps_r;
  end

  // Snapshot for the link side, refreshed only while chip select is high,
  // so a status poll sees the value at the start of its frame.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snap1_r   <= '0;
      snap2_r   <= '0;
      snap3_r   <= '0;
      snap_pd_r <= 1'b0;
    end else if (cs_s2_r) begin
      snap1_r   <= sr1;
      snap2_r   <= sr2;
      snap3_r   <= sr3;
      snap_pd_r <= pd_r;
    end
  end

  assign busy_o       = busy;
  assign power_down_o = pd_r;

endmodule : sfwp_write_protect

// file: dv/sfwp_wp_assertions.sv
/*
  Checker of the write-protect block ports.
  Assumes array_done_i pulses only during an array operation.
*/
`timescale 1ns/1ns
module sfwp_wp_assertions #(
  parameter int unsigned PUW_CYCLES = 50000
) (
  input wire logic core_clk_i,   // Core clock.
  input wire logic rstn_i,       // Reset, active low.
  input wire logic cs_n_i,       // Chip select.
  input wire logic array_done_i, // Engine done.
  input wire logic miso_oe_o,    // Drive enable.
  input wire logic array_go_o,   // Start pulse.
  input wire logic suspend_o,    // Suspend pulse.
  input wire logic busy_o,       // Busy flag.
  input wire logic power_down_o  // Power-down.
);
  logic [31:0] age_r;
  // Saturates so a long run never wraps back into the lockout.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      age_r <= 32'h0000_0000;
    end else if (age_r < PUW_CYCLES) begin
      age_r <= age_r + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_LOCKOUT: assert property (age_r < PUW_CYCLES |-> !array_go_o && !busy_o)
    else $error("work started in lockout");
  AST_GO_BUSY: assert property (array_go_o |-> busy_o)
    else $error("start without busy");
  AST_GO_ONE: assert property (array_go_o |=> !array_go_o)
    else $error("start pulse too long");
  AST_BUSY_HOLD: assert property (busy_o && $past(busy_o) |-> !array_go_o)
    else $error("start while busy");
  AST_DONE_CLR: assert property (busy_o && array_done_i |=> !busy_o)
    else $error("busy kept after done");
  AST_SUSP_BUSY: assert property (suspend_o |-> busy_o)
    else $error("suspend while idle");
  AST_PD_QUIET: assert property (power_down_o |-> !miso_oe_o && !array_go_o)
    else $error("activity in power-down");
  AST_SRW_LEN: assert property ($rose(busy_o) && !array_go_o |-> busy_o [*8])
    else $error("status write too short");
  AST_PD_STEADY: assert property (!cs_n_i && $past(!cs_n_i) |-> $stable(power_down_o))
    else $error("power-down changed in frame");
endmodule // sfwp_wp_assertions

bind sfwp_write_protect sfwp_wp_assertions #(.PUW_CYCLES(PUW_CYCLES)) chk_u (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
  .array_done_i(array_done_i), .miso_oe_o(miso_oe_o), .array_go_o(array_go_o),
  .suspend_o(suspend_o), .busy_o(busy_o), .power_down_o(power_down_o));

// file: dv/sfwp_spi_host.sv
/*
  SPI host model: mode 0 frames, MSB first, 80 ns link clock only in frames.
  Assumes the device drives its data line on falling edges.
*/
`timescale 1ns/1ns
module sfwp_spi_host (
  output logic      sclk_o, // Link clock.
  output logic      cs_n_o, // Chip select, active low.
  output logic      mosi_o, // Data to device.
  input  wire logic miso_i, // Data from device.
  input  wire logic oe_i    // Device drive enable.
);
  logic last_r = 1'b0;
  // An undriven line shows the inverse of its last level, so no drive cannot pass.
  wire line_w = oe_i ? miso_i : ~last_r;
  always @(miso_i or oe_i) if (oe_i) last_r = miso_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Sends n bits of d and returns the last byte read after the opcode.
  task automatic frame(input logic [47:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_o = d[47-i];
      #40 sclk_o = 1'b1;
      if (i >= 8) rd = {rd[6:0], line_w};
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #200;
  endtask
endmodule // sfwp_spi_host

// file: dv/tb_serial_flash_write_protect.sv
/*
  Bench of the write-protect block: random range checks plus corner cases.
  Assumes the SPI host model and the bound checker.
*/
`timescale 1ns/1ns
module tb_serial_flash_write_protect;
  import sfwp_pkg::*;
  localparam int unsigned PUW = 200;
  logic clk = 0, rstn = 0, wp_n = 1, done = 0;
  wire  sclk, cs_n, mosi, miso, oe, go, susp, busy, pd;
  wire  [2:0] kind;
  wire  [23:0] addr;
  int   num_errors = 0, n_compared = 0, n_go = 0, n_susp = 0;
  logic [31:0] seed = 10;
  logic [7:0] rd, sr1;
  logic [23:0] a;
  logic c;
  always #10 clk = ~clk;
  sfwp_write_protect #(.PUW_CYCLES(PUW)) dut_u (.core_clk_i(clk), .rstn_i(rstn),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .wp_n_i(wp_n), .array_done_i(done),
    .miso_o(miso), .miso_oe_o(oe), .array_go_o(go), .array_kind_o(kind),
    .array_addr_o(addr), .suspend_o(susp), .busy_o(busy), .power_down_o(pd));
  sfwp_spi_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .oe_i(oe));
  // Pulse counters; the checks compare their growth across the frames of one erase call.
  always @(posedge clk) begin
    if (go) n_go <= n_go + 1;
    if (susp) n_susp <= n_susp + 1;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Protected state of a sector under the range scheme.
  function automatic logic prot(input logic [7:0] s, input logic cm, input logic [23:0] ad);
    int n;
    logic p;
    n = s[6] ? ((s[4:2] >= 4) ? 8 : (1 << (s[4:2] - 1))) : (16 << (s[4:2] - 1));
    p = s[5] ? (ad[23:12] < n) : (ad[23:12] >= 1024 - n);
    if (s[4:2] == 3'h0) p = 1'b0;
    if (s[4:2] == 3'h7) p = 1'b1;
    return p ^ cm;
  endfunction
  task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic summarize();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmd(input logic [47:0] d, input int n);
    host_u.frame(d, n, rd);
  endtask
  task automatic rdsr(input logic [7:0] op, input logic [7:0] e, input string w);
    host_u.frame({op, 40'h0}, 16, rd);
    check(w, e, rd);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
    check("busy", 0, busy);
    if (busy !== 1'b0) summarize();
  endtask
  // Write enable, then a status write or unlock frame; this task always enables first.
  task automatic wrs(input logic [7:0] op, input logic [15:0] v, input int n);
    cmd({8'h06, 40'h0}, 8);
    cmd({op, v, 24'h0}, n);
    wait_idle();
  endtask
  task automatic erase(input logic [23:0] ea, input logic e, input logic mid);
    int g;
    int s;
    cmd({8'h06, 40'h0}, 8);
    g = n_go;
    s = n_susp;
    cmd({8'h20, ea, 16'h0}, 32);
    check("go", e, n_go - g);
    if (mid) cmd({8'h06, 40'h0}, 8);
    if (mid) cmd({8'h75, 40'h0}, 8);
    check("suspend", mid, n_susp - s);
    if (n_go != g) check("addr", ea, addr);
    if (n_go != g) check("kind", SFWP_K_SE, kind);
    @(negedge clk) done = n_go != g;
    @(negedge clk) done = 1'b0;
    wait_idle();
    rdsr(8'h05, sr1, "sr1 erase");
  endtask
  task automatic por();
    @(negedge clk) rstn = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (PUW + 4) @(negedge clk);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    cmd({8'h06, 40'h0}, 8);
    rdsr(8'h05, 8'h00, "sr1 lockout");
    repeat (PUW) @(negedge clk);
    rdsr(8'h35, 8'h00, "sr2 reset");
    rdsr(8'h15, 8'h00, "sr3 reset");
    cmd({8'h01, 8'h1C, 32'h0}, 16);
    rdsr(8'h05, 8'h00, "sr1 no latch");
    cmd({8'h06, 40'h0}, 8);
    rdsr(8'h05, 8'h02, "sr1 latch");
    cmd({8'h04, 40'h0}, 8);
    rdsr(8'h05, 8'h00, "sr1 disabled");
    for (int i = 0; i < 10; i++) begin
      sr1 = 8'(rnd()) & 8'h7C;
      c = rnd() & 1;
      @(negedge clk) wp_n = rnd() & 1;
      wrs(8'h01, {sr1, 1'b0, c, 6'h0}, 24);
      rdsr(8'h05, sr1, "sr1 range");
      for (int j = 0; j < 3; j++) begin
        a = (j == 0) ? 24'h00_0000 : (j == 1) ? 24'h3F_F000 : 24'(rnd()) & 24'h3F_F000;
        erase(a, !prot(sr1, c, a), 1'b0);
      end
    end
    sr1 = 8'h00;
    wrs(8'h01, 16'h0000, 24);
    erase(24'h12_3000, 1'b1, 1'b1);
    wrs(8'h11, 16'h0400, 16);
    erase(24'h12_3000, 1'b0, 1'b0);
    wrs(8'h39, 16'h1230, 32);
    wrs(8'h39, 16'h0000, 32);
    erase(24'h12_3000, 1'b1, 1'b0);
    erase(24'h00_1000, 1'b0, 1'b0);
    erase(24'h00_0000, 1'b1, 1'b0);
    wrs(8'h01, 16'h8000, 16);
    @(negedge clk) wp_n = 1'b0;
    wrs(8'h01, 16'h8400, 16);
    rdsr(8'h05, 8'h82, "wp low");
    @(negedge clk) wp_n = 1'b1;
    wrs(8'h01, 16'h8400, 16);
    rdsr(8'h05, 8'h84, "wp high");
    for (int m = 2; m < 4; m++) begin
      wrs(8'h01, {m[0], 14'h0, m[1]}, 24);
      wrs(8'h01, 16'h0000, 24);
      rdsr(8'h35, 8'h01, "sr2 locked");
      por();
      rdsr(8'h35, 8'h00, "sr2 por");
    end
    cmd({8'hB9, 40'h0}, 8);
    check("power down", 1, pd);
    cmd({8'h06, 40'h0}, 8);
    cmd({8'hAB, 40'h0}, 8);
    check("power down", 0, pd);
    rdsr(8'h05, 8'h00, "sr1 pd");
    summarize();
  end
endmodule // tb_serial_flash_write_protect
